/* File: rtl/liu_pkg.sv */
// Constants and types shared by the local interrupt unit.
package liu_pkg;
    // ==========================================================
    // Register map and fields
    // ==========================================================
    localparam logic [7:0]  IRQ_UNIT_BASE_ADDR  = 8'h1b;
    localparam int          BASE_ENABLE_BIT     = 11;
    localparam logic [63:0] IRQ_UNIT_BASE_RESET = 64'h0000_0000_0000_0800;
    localparam int          POWER_ON_LOWPWR_BIT = 26;
    localparam int          ENTRY_MODE_LSB      = 8;
    localparam int          ENTRY_MASK_BIT      = 16;
    localparam logic [2:0]  MODE_LEGACY         = 3'h7;
    localparam logic [31:0] ENTRY_RESET         = 32'h0001_0000;
    localparam logic [7:0]  VECTOR_RESERVED_SPUR = 8'h0f;
    localparam logic [7:0]  VECTOR_ZERO         = 8'h00;
    localparam logic [7:0]  DEFAULT_SPUR_VECTOR = 8'hff;
    // ==========================================================
    // Timing
    // ==========================================================
    localparam int          CLK_PERIOD_NS       = 5;
    localparam int          BOOT_TIMEOUT_NS     = 10000;
    localparam int          BOOT_TIMEOUT_CYC    = BOOT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int          ACK_TIMEOUT_NS      = 1000;
    localparam int          ACK_TIMEOUT_CYC     = ACK_TIMEOUT_NS / CLK_PERIOD_NS;
    // ==========================================================
    // States
    // ==========================================================
    typedef enum logic [1:0] {CPU_RUN, CPU_WAIT_START, CPU_HALT} liu_cpu_e;
    typedef enum logic [1:0] {ACK_IDLE, ACK_INT, ACK_EXT} liu_ack_e;
    typedef enum logic [1:0] {BOOT_WAIT, BOOT_DONE, BOOT_FAIL} liu_boot_e;
endpackage

/* File: rtl/liu_local_irq_unit.sv */
// Local interrupt unit: startup handshake, boot determination, legacy delivery.
`timescale 1ns/1ps
module liu_local_irq_unit #(
    parameter int BOOT_TIMEOUT = liu_pkg::BOOT_TIMEOUT_CYC
) (
    input  wire logic        clk_sys,
    input  wire logic        arst_n,
    input  wire logic        msrWrite,
    input  wire logic        msrRead,
    input  wire logic [7:0]  msrAddr,
    input  wire logic [63:0] msrWdata,
    output logic      [63:0] msrRdata,
    input  wire logic        powerOnLowPower,
    input  wire logic        entryWrite,
    input  wire logic        entrySel,
    input  wire logic [31:0] entryWdata,
    input  wire logic        initMessage,
    input  wire logic        startupMessage,
    input  wire logic [7:0]  startupVector,
    input  wire logic        bootBusDataLow,
    input  wire logic        bootWon,
    input  wire logic        bootLost,
    output logic             internalErrorOutN,
    output logic             cpuRun,
    output logic             coreClockEnable,
    output logic [19:0]      startAddress,
    output logic             startPulse,
    input  wire logic        localIrqLine0,
    input  wire logic        localIrqLine1,
    input  wire logic [7:0]  legacySpurVector,
    output logic             coreIrq,
    input  wire logic        coreAck,
    output logic             coreVectorValid,
    output logic [7:0]       coreVector,
    output logic             extAckReq,
    input  wire logic        extAckDone,
    input  wire logic [7:0]  extAckVector,
    input  wire logic        serialIrq,
    input  wire logic [7:0]  serialVector,
    output logic             serialPending,
    input  wire logic        serialAck
);
    import liu_pkg::*;

    typedef struct packed {
        logic [63:0] base;
        logic [31:0] entry0;
        logic [31:0] entry1;
        liu_cpu_e    cpu;
        liu_boot_e   boot;
        logic [31:0] bootCnt;
        liu_ack_e    ack;
        logic        ackSpur;
        logic        irqOut;
        logic        serialHeld;
        logic [7:0]  serialVec;
        logic        vecValid;
        logic [7:0]  vec;
        logic [19:0] startAddr;
        logic        start;
        logic        errN;
        logic [63:0] rdata;
    } liu_state_s;

    liu_state_s r;
    liu_state_s next_r;
    logic [1:0] rstSync;
    logic       rstN;

    function automatic logic isLegacy(input logic [31:0] e);
        isLegacy = e[ENTRY_MODE_LSB +: 3] == MODE_LEGACY;
    endfunction

    function automatic logic lineLive(input logic [31:0] e, input logic line);
        lineLive = isLegacy(e) && !e[ENTRY_MASK_BIT] && line;
    endfunction

    assign rstN = rstSync[1];

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb begin
        logic enabled;
        logic live;
        enabled = r.base[BASE_ENABLE_BIT];
        live = enabled && (lineLive(r.entry0, localIrqLine0)
                           || lineLive(r.entry1, localIrqLine1));
        next_r = r;
        next_r.start = 1'b0;
        next_r.vecValid = 1'b0;
        if (msrWrite && msrAddr == IRQ_UNIT_BASE_ADDR) begin
            next_r.base = msrWdata;
        end
        if (msrRead) begin
            next_r.rdata = (msrAddr == IRQ_UNIT_BASE_ADDR) ? r.base : 64'h0;
        end
        if (entryWrite) begin
            if (entrySel) begin
                next_r.entry1 = entryWdata;
            end else begin
                next_r.entry0 = entryWdata;
            end
        end
        // Boot determination: a stuck-low bus must not hang silently.
        case (r.boot)
            BOOT_WAIT: begin
                next_r.bootCnt = r.bootCnt + 32'h1;
                if (bootBusDataLow || r.bootCnt >= 32'(BOOT_TIMEOUT)) begin
                    next_r.boot = BOOT_FAIL;
                    next_r.errN = 1'b0;
                end else if (bootWon) begin
                    next_r.boot = BOOT_DONE;
                end else if (bootLost) begin
                    next_r.boot = BOOT_DONE;
                    next_r.cpu = CPU_WAIT_START;
                end
            end
            BOOT_DONE: next_r.boot = BOOT_DONE;
            BOOT_FAIL: next_r.errN = 1'b0;
            default:   next_r.boot = BOOT_WAIT;
        endcase
        // Startup handshake. Init wins over a startup in the same cycle so a
        // late init can never leave the processor running from address zero.
        if (initMessage) begin
            next_r.cpu = CPU_WAIT_START;
        end else begin
            case (r.cpu)
                CPU_WAIT_START: begin
                    if (startupMessage) begin
                        next_r.cpu = CPU_RUN;
                        next_r.startAddr = {startupVector, 12'h000};
                        next_r.start = 1'b1;
                    end
                end
                CPU_RUN:  next_r.cpu = CPU_RUN;
                CPU_HALT: next_r.cpu = CPU_HALT;
                default:  next_r.cpu = CPU_WAIT_START;
            endcase
        end
        // Serial interrupt stays held until its own acknowledge arrives. A new one in the
        // cycle of the old one's acknowledge is kept, so it can never be lost.
        if (serialIrq && (!r.serialHeld || serialAck)) begin
            next_r.serialHeld = 1'b1;
            next_r.serialVec = serialVector;
        end else if (serialAck) begin
            next_r.serialHeld = 1'b0;
        end
        // Legacy acknowledge path.
        next_r.irqOut = live && r.ack == ACK_IDLE;
        case (r.ack)
            ACK_IDLE: begin
                if (live && coreAck) begin
                    next_r.ack = ACK_INT;
                    next_r.ackSpur = 1'b0;
                end
            end
            ACK_INT: begin
                next_r.ack = ACK_EXT;
                next_r.ackSpur = r.ackSpur | !live;
            end
            ACK_EXT: begin
                if (!live) begin
                    next_r.ackSpur = 1'b1;
                end
                if (extAckDone) begin
                    next_r.ack = ACK_IDLE;
                    next_r.vecValid = 1'b1;
                    if (r.ackSpur || !live || extAckVector == VECTOR_ZERO
                        || extAckVector == VECTOR_RESERVED_SPUR) begin
                        next_r.vec = legacySpurVector;
                    end else begin
                        next_r.vec = extAckVector;
                    end
                    next_r.irqOut = 1'b0;
                end
            end
            default: next_r.ack = ACK_IDLE;
        endcase
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // The synchroniser stays outside the state struct: it is the only state cleared by the pin.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rstSync <= 2'b00;
        end else begin
            rstSync <= {rstSync[0], 1'b1};
        end
    end

    always_ff @(posedge clk_sys or negedge rstN) begin
        if (!rstN) begin
            r.base       <= IRQ_UNIT_BASE_RESET;
            r.entry0     <= ENTRY_RESET;
            r.entry1     <= ENTRY_RESET;
            r.cpu        <= CPU_RUN;
            r.boot       <= BOOT_WAIT;
            r.bootCnt    <= 32'h0;
            r.ack        <= ACK_IDLE;
            r.ackSpur    <= 1'b0;
            r.irqOut     <= 1'b0;
            r.serialHeld <= 1'b0;
            r.serialVec  <= 8'h00;
            r.vecValid   <= 1'b0;
            r.vec        <= DEFAULT_SPUR_VECTOR;
            r.startAddr  <= 20'h00000;
            r.start      <= 1'b0;
            r.errN       <= 1'b1;
            r.rdata      <= 64'h0;
        end else begin
            r.base       <= next_r.base;
            r.entry0     <= next_r.entry0;
            r.entry1     <= next_r.entry1;
            r.cpu        <= next_r.cpu;
            r.boot       <= next_r.boot;
            r.bootCnt    <= next_r.bootCnt;
            r.ack        <= next_r.ack;
            r.ackSpur    <= next_r.ackSpur;
            r.irqOut     <= next_r.irqOut;
            r.serialHeld <= next_r.serialHeld;
            r.serialVec  <= next_r.serialVec;
            r.vecValid   <= next_r.vecValid;
            r.vec        <= next_r.vec;
            r.startAddr  <= next_r.startAddr;
            r.start      <= next_r.start;
            r.errN       <= next_r.errN;
            r.rdata      <= next_r.rdata;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign msrRdata          = r.rdata;
    assign internalErrorOutN = r.errN;
    assign cpuRun            = r.cpu == CPU_RUN;
    // The core clock only sleeps while waiting for a startup message.
    assign coreClockEnable   = !(powerOnLowPower && r.cpu == CPU_WAIT_START);
    assign startAddress      = r.startAddr;
    assign startPulse        = r.start;
    assign coreIrq           = r.irqOut;
    assign coreVectorValid   = r.vecValid;
    assign coreVector        = r.vec;
    assign extAckReq         = r.ack == ACK_EXT;
    assign serialPending     = r.serialHeld;
endmodule

/* File: sim/liu_checker.sv */
// Port-level assertions for the local interrupt unit.
`timescale 1ns/1ps
// ==========================================================
// Checker
// ==========================================================
module liu_checker (
    input wire logic        clk_sys,
    input wire logic        arst_n,
    input wire logic        bootBusDataLow,
    input wire logic        internalErrorOutN,
    input wire logic        initMessage,
    input wire logic        startupMessage,
    input wire logic [7:0]  startupVector,
    input wire logic        cpuRun,
    input wire logic        startPulse,
    input wire logic [19:0] startAddress,
    input wire logic        coreClockEnable,
    input wire logic        coreAck,
    input wire logic        coreIrq,
    input wire logic        extAckReq,
    input wire logic        extAckDone,
    input wire logic        coreVectorValid,
    input wire logic [7:0]  coreVector,
    input wire logic        entryWrite,
    input wire logic        entrySel,
    input wire logic [31:0] entryWdata,
    input wire logic        localIrqLine1
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    err_flag_a: assert property (bootBusDataLow |=> !internalErrorOutN)
        else $error("error output not raised");
    init_halt_a: assert property (initMessage |=> !cpuRun)
        else $error("init did not halt");
    start_run_a: assert property (startupMessage && !initMessage && !cpuRun |=>
        cpuRun && startPulse && startAddress == {$past(startupVector), 12'h000})
        else $error("startup did not start at vector");
    clk_run_a: assert property (cpuRun |-> coreClockEnable)
        else $error("core clock stopped while running");
    ack_ext_a: assert property (coreAck && coreIrq && !extAckReq |-> ##[1:3] extAckReq)
        else $error("acknowledge not sent outside");
    ack_hold_a: assert property (extAckReq && !extAckDone |=> extAckReq)
        else $error("external acknowledge dropped early");
    vec_done_a: assert property (extAckReq && extAckDone |=> coreVectorValid)
        else $error("vector not returned");
    vec_legal_a: assert property (coreVectorValid |->
        coreVector != 8'h0f && coreVector != 8'h00)
        else $error("illegal vector returned");
    mask_drop_a: assert property (entryWrite && !entrySel && entryWdata[16] && !localIrqLine1
        |=> ##1 !coreIrq)
        else $error("mask did not withdraw interrupt");
    cover property (startPulse);
    cover property (extAckReq && extAckDone);
    cover property ($fell(internalErrorOutN));
endmodule
bind liu_local_irq_unit liu_checker chk (.*);

/* File: sim/liu_legacy_model.sv */
// Behavioural legacy interrupt controller answering acknowledge cycles.
`timescale 1ns/1ps
// ==========================================================
// Legacy controller model
// ==========================================================
module liu_legacy_model (
    input  wire logic       clk_sys,
    input  wire logic       extAckReq,
    input  wire logic [7:0] vecIn,
    input  wire logic [3:0] waitCyc,
    output logic            extAckDone,
    output logic      [7:0] extAckVector
);
    logic [3:0] cnt = 4'h0;
    initial extAckDone = 1'b0;
    initial extAckVector = 8'h00;
    // Outside an answer the vector bus toggles, so a stale vector can never pass.
    always @(posedge clk_sys) begin
        extAckDone <= 1'b0;
        extAckVector <= ~extAckVector;
        if (extAckReq && !extAckDone && cnt >= waitCyc) begin
            extAckDone <= 1'b1;
            extAckVector <= vecIn;
            cnt <= 4'h0;
        end else if (extAckReq) begin
            cnt <= cnt + 4'h1;
        end else begin
            cnt <= 4'h0;
        end
    end
endmodule

/* File: sim/local_irq_unit_startup_delivery_test.sv */
// Self-checking bench for the local interrupt unit.
`timescale 1ns/1ps
// ==========================================================
// Bench
// ==========================================================
module local_irq_unit_startup_delivery_test;
    import liu_pkg::*;
    logic        clk_sys, arst_n, msrWrite, msrRead, powerOnLowPower, entryWrite, entrySel;
    logic        initMessage, startupMessage, bootBusDataLow, bootWon, bootLost, serialAck;
    logic        localIrqLine0, localIrqLine1, coreAck, serialIrq, internalErrorOutN, cpuRun;
    logic        coreClockEnable, startPulse, coreIrq, coreVectorValid, extAckReq, extAckDone;
    logic        serialPending;
    logic [7:0]  msrAddr, startupVector, legacySpurVector, coreVector, extAckVector;
    logic [7:0]  serialVector, modelVec;
    logic [3:0]  modelWait;
    logic [19:0] startAddress;
    logic [31:0] entryWdata;
    logic [63:0] msrWdata, msrRdata, rdv;
    int          err_total, samples_checked;
    liu_local_irq_unit #(.BOOT_TIMEOUT(20)) dut (.*);
    liu_legacy_model model (.clk_sys(clk_sys), .extAckReq(extAckReq), .vecIn(modelVec),
        .waitCyc(modelWait), .extAckDone(extAckDone), .extAckVector(extAckVector));
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    task cyc(input int n); repeat (n) @(posedge clk_sys); #1; endtask
    task chk(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task rst(); arst_n = 1'b0; cyc(5); arst_n = 1'b1; cyc(3); endtask
    task wr(input logic [7:0] a, input logic [63:0] d);
        msrAddr = a; msrWdata = d; msrWrite = 1'b1; cyc(1); msrWrite = 1'b0; cyc(1);
    endtask
    task rd(input logic [7:0] a);
        msrAddr = a; msrRead = 1'b1; cyc(1); msrRead = 1'b0; rdv = msrRdata; cyc(1);
    endtask
    task ent(input logic s, input logic [31:0] d);
        entrySel = s; entryWdata = d; entryWrite = 1'b1; cyc(1); entryWrite = 1'b0; cyc(1);
    endtask
    task wake(input logic [7:0] v, input int n);
        initMessage = 1'b1; cyc(1); initMessage = 1'b0; cyc(1);
        chk(cpuRun, 1'b0);
        chk(coreClockEnable, !powerOnLowPower);
        for (int k = 0; k < n; k++) begin
            startupVector = v + 8'(k); startupMessage = 1'b1; cyc(1); startupMessage = 1'b0;
            if (k == 0)
                chk({startPulse, cpuRun, coreClockEnable, startAddress}, {3'h7, v, 12'h000});
            cyc(1);
        end
        chk(startAddress, {v, 12'h000});
    endtask
    task leg(input logic s, input logic drop, input logic [7:0] mv, input logic [7:0] ev,
             input logic [3:0] w);
        modelVec = mv; modelWait = w;
        ent(s, 32'h0000_0700);
        if (s) localIrqLine1 = 1'b1; else localIrqLine0 = 1'b1;
        cyc(2); chk(coreIrq, 1'b1);
        coreAck = 1'b1; cyc(1); coreAck = 1'b0;
        if (drop) begin
            {localIrqLine0, localIrqLine1, serialIrq} = 3'h1; cyc(1); serialIrq = 1'b0;
        end
        for (int i = 0; i < 20 && extAckReq !== 1'b1; i++) cyc(1);
        chk(extAckReq, 1'b1);
        for (int i = 0; i < 20 && coreVectorValid !== 1'b1; i++) cyc(1);
        chk(coreVectorValid, 1'b1); chk(coreVector, ev);
        if (drop) begin
            chk(serialPending, 1'b1); {serialAck, serialIrq} = 2'h3; cyc(1);
            {serialAck, serialIrq} = 2'h0; cyc(1); chk(serialPending, 1'b1);
            serialAck = 1'b1; cyc(1); serialAck = 1'b0; cyc(1);
            chk(serialPending, 1'b0);
        end
        {localIrqLine0, localIrqLine1} = 2'h0; ent(s, 32'h0001_0700); cyc(3);
    endtask
    task end_sim();
        $display("Checks %0d, errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #20000;
        err_total++;
        end_sim();
    end
    initial begin
        {msrWrite, msrRead, entryWrite, entrySel, initMessage, startupMessage, bootWon} = '0;
        {bootBusDataLow, bootLost, serialAck, localIrqLine0, localIrqLine1, coreAck} = '0;
        {serialIrq, msrAddr, startupVector, serialVector, modelVec, modelWait} = '0;
        {entryWdata, msrWdata, err_total, samples_checked} = '0;
        legacySpurVector = 8'h27; powerOnLowPower = 1'b1;
        rst(); bootLost = 1'b1; cyc(1); bootLost = 1'b0;
        rd(IRQ_UNIT_BASE_ADDR); chk(rdv, IRQ_UNIT_BASE_RESET);
        wr(8'h10, 64'hffff); rd(8'h10); chk(rdv, 64'h0);
        wr(IRQ_UNIT_BASE_ADDR, 64'hfee0_0800); rd(IRQ_UNIT_BASE_ADDR); chk(rdv, 64'hfee0_0800);
        wake(8'h9a, 2); powerOnLowPower = 1'b0; wake(8'h35, 1);
        leg(0, 0, 8'h42, 8'h42, 0); leg(0, 1, 8'h0f, 8'h27, 3);
        leg(0, 0, 8'h00, 8'h27, 2); leg(1, 0, 8'h5c, 8'h5c, 4);
        ent(0, 32'h0000_0700); localIrqLine0 = 1'b1; cyc(2); chk(coreIrq, 1'b1);
        ent(0, 32'h0001_0700); chk(coreIrq, 1'b0);
        ent(0, 32'h0000_0700); cyc(2); wr(IRQ_UNIT_BASE_ADDR, 64'h0);
        cyc(1); chk(coreIrq, 1'b0);
        localIrqLine0 = 1'b0; chk(internalErrorOutN, 1'b1);
        rst(); bootWon = 1'b1; cyc(1); bootWon = 1'b0; cyc(25);
        chk({internalErrorOutN, cpuRun}, 2'h3);
        rst(); cyc(25); chk(internalErrorOutN, 1'b0);
        rst(); bootBusDataLow = 1'b1; cyc(2); chk(internalErrorOutN, 1'b0);
        end_sim();
    end
endmodule
